// >>> hdl/csm_monitor.sv
// camera stream error counters, status fields and frame events
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module csm_monitor
  import csm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tag_loss_pulse,
  input wire logic byte_fixed_pulse,
  input wire logic multi_err_pulse,
  input wire logic ovf_pulse,
  input wire logic [3:0] ovf_port,
  input wire logic scan_kind_in,
  input wire logic [2:0] active_link_in,
  input wire logic cam_first_pixel,
  input wire logic cam_last_pixel,
  input wire logic trig_first_pixel,
  input wire logic trig_last_pixel,
  output logic frame_first_pixel_event,
  output logic frame_last_pixel_event,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] lost_packet_count;
    logic [11:0] fixed_byte_error_count;
    logic [11:0] multi_byte_error_count;
    logic [11:0] ovf_count;
    logic [3:0] ovf_source;
    logic scan_kind_flag;
    logic [2:0] active_link_count;
    logic run;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic start_ev;
    logic end_ev;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } csm_state_t;

  csm_state_t s_q;
  csm_state_t s_d;

  // ---------------------------------------------------------------
  // local limits
  // ---------------------------------------------------------------
  // the link field is three bits wide, yet only 1..4 is a legal reading
  localparam logic [2:0] LINKS_MIN = 3'h1;
  localparam logic [2:0] LINKS_MAX = 3'h4;
  localparam int LINKS_W = 3;
  localparam logic [11:0] CNT_CLEAR = 12'h000;
  localparam logic [3:0] SRC_CLEAR = 4'h0;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // all stream-side inputs share pclk, so no synchroniser is needed
  function automatic logic [11:0] sat_inc(input logic [11:0] v, input logic hit);
    if (hit && v != CSM_CNT_MAX) begin
      sat_inc = v + 12'h001;
    end else begin
      sat_inc = v;
    end
  endfunction : sat_inc

  // counters sit in the low bits, the rest of the word reads zero
  function automatic logic [31:0] cnt_word(input logic [11:0] c);
    cnt_word = {20'h00000, c};
  endfunction : cnt_word

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  function automatic logic wr_to(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    wr_to = wr && is_reg(a, ofs);
  endfunction : wr_to

  // anything off the map is answered with an error and has no effect
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = is_reg(a, CSM_LOST_OFS) ||
      is_reg(a, CSM_FIXED_OFS) ||
      is_reg(a, CSM_MULTI_OFS) ||
      is_reg(a, CSM_OVF_OFS) ||
      is_reg(a, CSM_STAT_OFS) ||
      is_reg(a, CSM_CTRL_OFS) ||
      is_reg(a, CSM_IRQ_STAT_OFS) ||
      is_reg(a, CSM_IRQ_MASK_OFS);
  endfunction : reg_mapped

  function automatic logic [31:0] stat_word(input csm_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CSM_STAT_SRC_LSB +: CSM_SRC_W] = st.ovf_source;
    w[CSM_STAT_SCAN_BIT] = st.scan_kind_flag;
    w[CSM_STAT_LINKS_LSB +: LINKS_W] = st.active_link_count;
    w[CSM_STAT_RUN_BIT] = st.run;
    stat_word = w;
  endfunction : stat_word

  // reads have no side effect, so the word is built from state only
  function automatic logic [31:0] read_word(input csm_state_t st, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      CSM_LOST_OFS: w = cnt_word(st.lost_packet_count);
      CSM_FIXED_OFS: w = cnt_word(st.fixed_byte_error_count);
      CSM_MULTI_OFS: w = cnt_word(st.multi_byte_error_count);
      CSM_OVF_OFS: w = cnt_word(st.ovf_count);
      CSM_STAT_OFS: w = stat_word(st);
      CSM_CTRL_OFS: w[CSM_CTRL_RUN_BIT] = st.run;
      CSM_IRQ_STAT_OFS: w[1:0] = st.irq_stat;
      CSM_IRQ_MASK_OFS: w[1:0] = st.irq_mask;
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction : read_word

  function automatic logic links_legal(input logic [2:0] n);
    links_legal = (n >= LINKS_MIN) && (n <= LINKS_MAX);
  endfunction : links_legal

  // an out-of-range link count is ignored and the last legal one stays
  function automatic logic [2:0] hold_links(input logic [2:0] old, input logic [2:0] n);
    if (links_legal(n)) begin
      hold_links = n;
    end else begin
      hold_links = old;
    end
  endfunction : hold_links

  // the last overflowing port is kept until the next overflow or start
  function automatic logic [3:0] latch_source(input logic [3:0] old, input logic hit,
    input logic [3:0] port);
    if (hit) begin
      latch_source = port;
    end else begin
      latch_source = old;
    end
  endfunction : latch_source

  // line frames come from the trigger stage, area frames from the camera
  function automatic logic pick_marker(input logic line_mode, input logic trig,
    input logic cam);
    if (line_mode) begin
      pick_marker = trig;
    end else begin
      pick_marker = cam;
    end
  endfunction : pick_marker

  // one input pulse moves its counter by one, never past the top
  function automatic csm_state_t count_events(input csm_state_t st, input logic [3:0] hits);
    csm_state_t r;
    r = st;
    // R1: saturating lost packet count
    r.lost_packet_count = sat_inc(st.lost_packet_count, hits[0]);
    // R2: corrected error count
    r.fixed_byte_error_count = sat_inc(st.fixed_byte_error_count, hits[1]);
    // R3: uncorrected error count
    r.multi_byte_error_count = sat_inc(st.multi_byte_error_count, hits[2]);
    // R4: overflow count
    r.ovf_count = sat_inc(st.ovf_count, hits[3]);
    count_events = r;
  endfunction : count_events

  function automatic csm_state_t clear_counts(input csm_state_t st);
    csm_state_t r;
    r = st;
    r.lost_packet_count = CNT_CLEAR;
    r.fixed_byte_error_count = CNT_CLEAR;
    r.multi_byte_error_count = CNT_CLEAR;
    r.ovf_count = CNT_CLEAR;
    r.ovf_source = SRC_CLEAR;
    clear_counts = r;
  endfunction : clear_counts

  function automatic logic [1:0] w1c(input logic [1:0] old, input logic [1:0] ones);
    w1c = old & ~ones;
  endfunction : w1c

  // applied after the clear, so an event in the clearing cycle is not lost
  function automatic logic [1:0] set_events(input logic [1:0] st, input logic start_ev,
    input logic end_ev);
    logic [1:0] r;
    r = st;
    if (start_ev) begin
      r[CSM_IRQ_START_BIT] = 1'b1;
    end
    if (end_ev) begin
      r[CSM_IRQ_END_BIT] = 1'b1;
    end
    set_events = r;
  endfunction : set_events

  function automatic logic irq_level(input logic [1:0] st, input logic [1:0] mask);
    irq_level = |(st & mask);
  endfunction : irq_level

  // ---------------------------------------------------------------
  // internal signals
  // ---------------------------------------------------------------
  logic take;
  logic wr_en;
  logic rd_en;
  logic rd_ok;
  logic start_hit;
  logic end_hit;
  logic run_rise;
  logic [31:0] rd_word;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // taken on the first access edge only; pready follows one cycle later
  assign take = psel && penable && !s_q.pready;
  assign wr_en = take && pwrite;
  assign rd_en = take && !pwrite;
  assign rd_ok = reg_mapped(paddr);
  assign rd_word = read_word(s_q, paddr);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    run_rise = 1'b0;

    // -------------------------------------------------------------
    // frame events
    // -------------------------------------------------------------
    // R10: line scan starts from trigger stage
    // R7: area scan starts at camera first pixel
    start_hit = pick_marker(s_q.scan_kind_flag, trig_first_pixel, cam_first_pixel);
    // R11: line scan end leaves trigger stage
    // R8: area scan end after last pixel
    end_hit = pick_marker(s_q.scan_kind_flag, trig_last_pixel, cam_last_pixel);
    // R9: gated by acquisition run
    s_d.start_ev = start_hit && s_q.run;
    s_d.end_ev = end_hit && s_q.run;

    // -------------------------------------------------------------
    // error counters
    // -------------------------------------------------------------
    // R13: counters hold at maximum
    s_d = count_events(s_d, {ovf_pulse, multi_err_pulse, byte_fixed_pulse, tag_loss_pulse});

    // -------------------------------------------------------------
    // status fields
    // -------------------------------------------------------------
    // scan kind follows its input live, one cycle late; links do so only while the input is in 1..4
    // R5: latch overflowing port
    s_d.ovf_source = latch_source(s_q.ovf_source, ovf_pulse, ovf_port);
    // R6: camera transfer mode
    s_d.scan_kind_flag = scan_kind_in;
    // R12: links in use, kept in 1..4
    s_d.active_link_count = hold_links(s_q.active_link_count, active_link_in);

    // -------------------------------------------------------------
    // bus answer
    // -------------------------------------------------------------
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (take) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !rd_ok;
    end
    // read data is held between reads so a late sample still sees it
    if (rd_en) begin
      s_d.prdata = rd_ok ? rd_word : 32'h0000_0000;
    end

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    // read-only offsets take a write without error and ignore it
    if (wr_to(wr_en, paddr, CSM_CTRL_OFS)) begin
      s_d.run = pwdata[CSM_CTRL_RUN_BIT];
      run_rise = pwdata[CSM_CTRL_RUN_BIT] && !s_q.run;
    end
    if (wr_to(wr_en, paddr, CSM_IRQ_MASK_OFS)) begin
      s_d.irq_mask = pwdata[1:0];
    end
    if (wr_to(wr_en, paddr, CSM_IRQ_STAT_OFS)) begin
      s_d.irq_stat = w1c(s_q.irq_stat, pwdata[1:0]);
    end

    // -------------------------------------------------------------
    // acquisition start
    // -------------------------------------------------------------
    // R14: acquisition start clears the four counters and the overflow source
    if (run_rise) begin
      s_d = clear_counts(s_d);
    end

    // -------------------------------------------------------------
    // interrupts
    // -------------------------------------------------------------
    // new events win over a write-one clear
    s_d.irq_stat = set_events(s_d.irq_stat, s_d.start_ev, s_d.end_ev);
    s_d.irq = irq_level(s_d.irq_stat, s_d.irq_mask);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R14: reset clears everything except the link count, which loads 1
      s_q <= '0;
      s_q.active_link_count <= CSM_LINKS_RST;
      s_q.irq_mask <= CSM_IRQ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign frame_first_pixel_event = s_q.start_ev;
  assign frame_last_pixel_event = s_q.end_ev;
  assign irq = s_q.irq;

endmodule : csm_monitor

// >>> hdl/csm_pkg.sv
// constants for the camera stream event monitor
// Contract
// R1: saturating lost packet counter, up to 4095
// R2: corrected single byte error counter, 4095
// R3: uncorrected multi byte error counter, 4095
// R4: packet buffer overflow counter, 4095 max
// R5: overflow source port field, 0 to 15
// R6: scan kind flag, 0 area, 1 line
// R7: frame start event on first pixel
// R8: frame end event after last pixel
// R9: events only while acquisition runs
// R10: line scan start with trigger first pixel
// R11: line scan end when pixel leaves trigger
// R12: active link count field, 1 to 4
// R13: counters saturate, never wrap
// R14: clear on reset and acquisition start
package csm_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CSM_LOST_OFS = 8'h00;
  localparam logic [7:0] CSM_FIXED_OFS = 8'h04;
  localparam logic [7:0] CSM_MULTI_OFS = 8'h08;
  localparam logic [7:0] CSM_OVF_OFS = 8'h0c;
  localparam logic [7:0] CSM_STAT_OFS = 8'h10;
  localparam logic [7:0] CSM_CTRL_OFS = 8'h14;
  localparam logic [7:0] CSM_IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] CSM_IRQ_MASK_OFS = 8'h1c;
  // ---------------------------------------------------------------
  // field layout and values
  // ---------------------------------------------------------------
  localparam int CSM_CNT_W = 12;
  localparam logic [11:0] CSM_CNT_MAX = 12'hfff;
  localparam int CSM_SRC_W = 4;
  localparam int CSM_STAT_SRC_LSB = 0;
  localparam int CSM_STAT_SCAN_BIT = 4;
  localparam int CSM_STAT_LINKS_LSB = 8;
  localparam int CSM_STAT_RUN_BIT = 12;
  localparam int CSM_CTRL_RUN_BIT = 0;
  localparam int CSM_IRQ_START_BIT = 0;
  localparam int CSM_IRQ_END_BIT = 1;
  localparam logic [2:0] CSM_LINKS_RST = 3'h1;
  localparam logic [1:0] CSM_IRQ_RST = 2'h0;
endpackage : csm_pkg

// >>> sim/csm_cam_model.sv
// camera side model: error pulses, pixel markers and live mode levels
`timescale 1ns/1ps
module csm_cam_model (
  input wire logic pclk,
  output logic [7:0] ev_q,
  output logic [3:0] port_q,
  output logic scan_q,
  output logic [2:0] links_q
);
  initial begin
    ev_q = 8'h00;
    port_q = 4'h0;
    scan_q = 1'b0;
    links_q = 3'h1;
  end
  // an idle cycle between pulses keeps every pulse a separate event
  task send(input logic [7:0] m, input int n);
    repeat (n) begin
      @(posedge pclk) ev_q <= m;
      @(posedge pclk) ev_q <= 8'h00;
    end
  endtask : send
endmodule : csm_cam_model

// >>> sim/csm_monitor_props.sv
// bus timing and frame event checks on the monitor ports
`timescale 1ns/1ps
module csm_monitor_props
  import csm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input logic pready,
  input logic pslverr,
  input wire logic scan_kind_in,
  input wire logic cam_first_pixel,
  input wire logic cam_last_pixel,
  input wire logic trig_first_pixel,
  input wire logic trig_last_pixel,
  input logic frame_first_pixel_event,
  input logic frame_last_pixel_event,
  input logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  a_ready_timing: assert property (setup_s ##1 access_s |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  a_err_range: assert property (pready && paddr > CSM_IRQ_MASK_OFS |-> pslverr)
    else $error("unmapped not refused");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_start_cause: assert property (frame_first_pixel_event |->
    ($past(scan_kind_in, 2) ? $past(trig_first_pixel) : $past(cam_first_pixel)))
    else $error("start uncaused");
  a_end_cause: assert property (frame_last_pixel_event |->
    ($past(scan_kind_in, 2) ? $past(trig_last_pixel) : $past(cam_last_pixel)))
    else $error("end uncaused");
  a_irq_cause: assert property ($rose(irq) |-> frame_first_pixel_event ||
    frame_last_pixel_event || $past(psel && pwrite)) else $error("irq uncaused");
endmodule : csm_monitor_props

// >>> sim/csm_monitor_tb_top.sv
// self-checking bench for the camera stream event monitor
`timescale 1ns/1ps
module csm_monitor_tb_top;
  import csm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, err, ffe, fle, irq, scan;
  logic [7:0] ev;
  logic [3:0] port;
  logic [2:0] links;
  int fail_count = 0, n_compared = 0;
  always #10 pclk = ~pclk;
  csm_cam_model u_csm_cam_model (.pclk, .ev_q(ev), .port_q(port), .scan_q(scan), .links_q(links));
  csm_monitor u_csm_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tag_loss_pulse(ev[0]), .byte_fixed_pulse(ev[1]),
    .multi_err_pulse(ev[2]), .ovf_pulse(ev[3]), .ovf_port(port), .scan_kind_in(scan),
    .active_link_in(links), .cam_first_pixel(ev[4]), .cam_last_pixel(ev[5]),
    .trig_first_pixel(ev[6]), .trig_last_pixel(ev[7]), .frame_first_pixel_event(ffe),
    .frame_last_pixel_event(fle), .irq);
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 16);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict;
    end
  endtask : xfer
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(CSM_LOST_OFS, 32'h0);
    rd(CSM_STAT_OFS, 32'h100);
    $display("test 1 done");
    xfer(1'b1, CSM_CTRL_OFS, 32'h1);
    xfer(1'b1, CSM_IRQ_MASK_OFS, 32'h3);
    u_csm_cam_model.send(8'h10, 1);
    @(posedge pclk) chk({31'h0, ffe}, 32'h1);
    rd(CSM_IRQ_STAT_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    u_csm_cam_model.send(8'h20, 1);
    @(posedge pclk) chk({31'h0, fle}, 32'h1);
    rd(CSM_IRQ_STAT_OFS, 32'h3);
    xfer(1'b1, CSM_IRQ_STAT_OFS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    $display("test 2 done");
    u_csm_cam_model.port_q <= 4'h9;
    u_csm_cam_model.send(8'h0f, 4100);
    for (int k = 0; k < 4; k++) rd(8'(4 * k), {20'h0, CSM_CNT_MAX});
    rd(CSM_STAT_OFS, 32'h1109);
    $display("test 3 done");
    u_csm_cam_model.scan_q <= 1'b1;
    u_csm_cam_model.links_q <= 3'h4;
    u_csm_cam_model.send(8'h30, 1);
    rd(CSM_IRQ_STAT_OFS, 32'h0);
    u_csm_cam_model.links_q <= 3'h7;
    u_csm_cam_model.send(8'h40, 1);
    u_csm_cam_model.send(8'h80, 1);
    rd(CSM_IRQ_STAT_OFS, 32'h3);
    rd(CSM_STAT_OFS, 32'h1419);
    $display("test 4 done");
    xfer(1'b1, CSM_CTRL_OFS, 32'h0);
    xfer(1'b1, CSM_IRQ_STAT_OFS, 32'h3);
    u_csm_cam_model.send(8'hc0, 1);
    rd(CSM_IRQ_STAT_OFS, 32'h0);
    xfer(1'b1, CSM_CTRL_OFS, 32'h1);
    xfer(1'b1, CSM_LOST_OFS, 32'h5);
    rd(CSM_LOST_OFS, 32'h0);
    rd(CSM_STAT_OFS, 32'h1410);
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, 8'h24, 32'h1);
    chk({31'h0, err}, 32'h1);
    $display("test 5 done");
    print_verdict;
  end
endmodule : csm_monitor_tb_top
bind csm_monitor csm_monitor_props u_csm_monitor_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .scan_kind_in, .cam_first_pixel, .cam_last_pixel,
  .trig_first_pixel, .trig_last_pixel, .frame_first_pixel_event, .frame_last_pixel_event, .irq);
